// ---- pdhp_pkg.sv ----
// Shared constants and types for the palette DAC host and pixel port
package pdhp_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int PIX_W   = 8;
  localparam int OVL_W   = 2;
  localparam int LANES   = 5;
  localparam int PAL_N   = 256;
  localparam int OVL_N   = 4;

  // ****************************************
  // Command select codes, {cmd_sel_1, cmd_sel_0}
  // ****************************************
  localparam logic [1:0] CMD_ADDR = 2'h0;
  localparam logic [1:0] CMD_PAL  = 2'h1;
  localparam logic [1:0] CMD_CTL  = 2'h2;
  localparam logic [1:0] CMD_OVL  = 2'h3;

  // ****************************************
  // Control register addresses, reached with CMD_CTL
  // ****************************************
  localparam logic [7:0] ADR_RMASK = 8'h04;
  localparam logic [7:0] ADR_BMASK = 8'h05;
  localparam logic [7:0] ADR_CMD   = 8'h06;
  localparam logic [7:0] ADR_DIAG  = 8'h07;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CMD_MUX_BIT  = 7;
  localparam int CMD_PEN_BIT  = 6;
  localparam int DIAG_NIB_BIT = 3;
  localparam int DIAG_BLU_BIT = 2;
  localparam int DIAG_GRN_BIT = 1;
  localparam int DIAG_RED_BIT = 0;

  // ****************************************
  // Values after reset, and last pixel slot for 4:1 and 5:1
  // ****************************************
  localparam logic [7:0] RST_CMD   = 8'h00;
  localparam logic [7:0] RST_RMASK = 8'hFF;
  localparam logic [7:0] RST_BMASK = 8'h00;
  localparam logic [3:0] RST_DIAG  = 4'h0;
  localparam logic [7:0] RST_ADDR  = 8'h00;
  localparam logic [2:0] LAST_4TO1 = 3'h3;
  localparam logic [2:0] LAST_5TO1 = 3'h4;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    RGB_RED   = 2'b00,
    RGB_GREEN = 2'b01,
    RGB_BLUE  = 2'b11
  } pdhp_rgb_type;

  typedef struct packed {
    logic [LANES*PIX_W-1:0] pix;
    logic [LANES*OVL_W-1:0] ovl;
    logic                   blank_n;
    logic                   sync_n;
  } pdhp_pixbus_type;

  typedef struct packed {
    logic             mux5;
    logic             pal_en;
    logic [PIX_W-1:0] rmask;
  } pdhp_cfg_type;

endpackage : pdhp_pkg

// ---- pdhp_port.sv ----
// Host port, diagnostic register and pixel multiplexer of the palette DAC
`timescale 1ns/1ns
// ****************************************
// ****************************************
module pdhp_port (
  input  wire logic        mclk_i,                // Host-side clock
  input  wire logic        rst_n_i,               // Synchronous reset, active low
  input  wire logic        pix_clk_i,             // Pixel clock
  input  wire logic        ce_n_i,                // Chip enable, active low
  input  wire logic        rw_i,                  // 1 read, 0 write
  input  wire logic        cmd_sel_0_i,           // Command select bit 0
  input  wire logic        cmd_sel_1_i,           // Command select bit 1
  input  wire logic [7:0]  data_i,                // Data bus input
  output logic      [7:0]  data_o,                // Data bus output
  output logic             data_oe_o,             // Data bus drive enable
  input  wire logic        load_strobe_n_i,       // Pixel load strobe
  input  wire logic [39:0] pixel_index_in_i,      // Pixels A..E, A low
  input  wire logic [9:0]  overlay_select_in_i,   // Overlay bits A..E
  input  wire logic        blank_n_i,             // Blank, active low
  input  wire logic        sync_n_i,              // Sync, active low
  output logic      [7:0]  dac_data_o,            // DAC input word
  output logic             blank_level_o,         // Blanking level active
  output logic             sync_current_on_o,     // Sync current on green out
  output logic             pll_current_on_o       // Lock reference current on
);

  // ****************************************
  // Host side synchronisers
  // ****************************************
  logic [11:0] hin_s1_reg;
  logic [11:0] hin_s2_reg;
  logic        ce_s3_reg;
  logic        ce_s2, rw_s2;
  logic [1:0]  cmd_s2;
  logic [7:0]  dat_s2;
  logic        ce_fall, ce_rise;

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      hin_s1_reg <= 12'hFFF;
      hin_s2_reg <= 12'hFFF;
      ce_s3_reg  <= 1'b1;
    end
    else
    begin
      hin_s1_reg <= {ce_n_i, rw_i, cmd_sel_1_i, cmd_sel_0_i, data_i};
      hin_s2_reg <= hin_s1_reg;
      ce_s3_reg  <= ce_s2;
    end
  end

  assign ce_s2   = hin_s2_reg[11];
  assign rw_s2   = hin_s2_reg[10];
  assign cmd_s2  = hin_s2_reg[9:8];
  assign dat_s2  = hin_s2_reg[7:0];
  assign ce_fall = ce_s3_reg & ~ce_s2;
  assign ce_rise = ~ce_s3_reg & ce_s2;

  // ****************************************
  // Host access control
  // ****************************************
  logic [7:0]         addr_reg;
  logic [1:0]         cmd_lat_reg;
  logic               rw_lat_reg;
  logic [3:0]         diag_reg;
  logic [7:0]         cmd_reg, rmask_reg, bmask_reg;
  pdhp_pkg::pdhp_rgb_type phase_reg, phase_next;
  logic               triplet, slot_match, color_acc, acc_done;
  logic [7:0]         pal_mem [pdhp_pkg::PAL_N];
  logic [7:0]         ovl_mem [pdhp_pkg::OVL_N];

  assign triplet   = |diag_reg[2:0];
  assign color_acc = (cmd_lat_reg == pdhp_pkg::CMD_PAL) || (cmd_lat_reg == pdhp_pkg::CMD_OVL);
  assign acc_done  = !triplet || (phase_reg == pdhp_pkg::RGB_BLUE);

  always_comb
  begin
    slot_match = 1'b1;
    if (triplet)
    begin
      case (phase_reg)
        pdhp_pkg::RGB_RED:   slot_match = diag_reg[pdhp_pkg::DIAG_RED_BIT];
        pdhp_pkg::RGB_GREEN: slot_match = diag_reg[pdhp_pkg::DIAG_GRN_BIT];
        pdhp_pkg::RGB_BLUE:  slot_match = diag_reg[pdhp_pkg::DIAG_BLU_BIT];
        default:             slot_match = 1'b0;
      endcase
    end
  end

  always_comb
  begin
    case (phase_reg)
      pdhp_pkg::RGB_RED:   phase_next = pdhp_pkg::RGB_GREEN;
      pdhp_pkg::RGB_GREEN: phase_next = pdhp_pkg::RGB_BLUE;
      default:             phase_next = pdhp_pkg::RGB_RED;
    endcase
  end

  // Direction and command captured at the falling edge
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      rw_lat_reg  <= 1'b1;
      cmd_lat_reg <= pdhp_pkg::CMD_ADDR;
    end
    else if (ce_fall)
    begin
      rw_lat_reg  <= rw_s2;
      cmd_lat_reg <= cmd_s2;
    end
  end

  // Writes commit on the rising edge only
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      addr_reg  <= pdhp_pkg::RST_ADDR;
      phase_reg <= pdhp_pkg::RGB_RED;
      cmd_reg   <= pdhp_pkg::RST_CMD;
      rmask_reg <= pdhp_pkg::RST_RMASK;
      bmask_reg <= pdhp_pkg::RST_BMASK;
      diag_reg  <= pdhp_pkg::RST_DIAG;
    end
    else if (ce_rise)
    begin
      if (cmd_lat_reg == pdhp_pkg::CMD_ADDR)
      begin
        if (!rw_lat_reg)
        begin
          addr_reg  <= dat_s2;
          phase_reg <= pdhp_pkg::RGB_RED;
        end
      end
      else if (color_acc)
      begin
        if (triplet)
          phase_reg <= phase_next;
        if (acc_done)
          addr_reg <= addr_reg + 8'h01;
      end
      else if (!rw_lat_reg)
      begin
        case (addr_reg)
          pdhp_pkg::ADR_RMASK: rmask_reg <= dat_s2;
          pdhp_pkg::ADR_BMASK: bmask_reg <= dat_s2;
          pdhp_pkg::ADR_CMD:   cmd_reg   <= dat_s2;
          pdhp_pkg::ADR_DIAG:  diag_reg  <= dat_s2[3:0];
          default:             diag_reg  <= diag_reg;
        endcase
      end
    end
  end

  // Palette storage has no reset, like any RAM
  always_ff @(posedge mclk_i)
  begin
    if (ce_rise && !rw_lat_reg && color_acc && slot_match)
    begin
      if (cmd_lat_reg == pdhp_pkg::CMD_PAL)
        pal_mem[addr_reg] <= dat_s2;
      else
        ovl_mem[addr_reg[1:0]] <= dat_s2;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  logic       in_read_reg, oe_reg;
  logic [7:0] rd_data_reg, rd_data_next, dac_snap_reg;
  logic [3:0] nibble;

  assign nibble = diag_reg[pdhp_pkg::DIAG_NIB_BIT] ? dac_snap_reg[3:0]
                                                   : dac_snap_reg[7:4];

  always_comb
  begin
    case (cmd_lat_reg)
      pdhp_pkg::CMD_ADDR: rd_data_next = addr_reg;
      pdhp_pkg::CMD_PAL:  rd_data_next = pal_mem[addr_reg];
      pdhp_pkg::CMD_OVL:  rd_data_next = ovl_mem[addr_reg[1:0]];
      default:
      begin
        case (addr_reg)
          pdhp_pkg::ADR_RMASK: rd_data_next = rmask_reg;
          pdhp_pkg::ADR_BMASK: rd_data_next = bmask_reg;
          pdhp_pkg::ADR_CMD:   rd_data_next = cmd_reg;
          pdhp_pkg::ADR_DIAG:  rd_data_next = {nibble, diag_reg};
          default:             rd_data_next = 8'h00;
        endcase
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      in_read_reg <= 1'b0;
      oe_reg      <= 1'b0;
      rd_data_reg <= 8'h00;
    end
    else
    begin
      if (ce_fall)
        in_read_reg <= rw_s2 && (!(cmd_s2 == pdhp_pkg::CMD_PAL ||
                       cmd_s2 == pdhp_pkg::CMD_OVL) || slot_match);
      else if (ce_rise)
        in_read_reg <= 1'b0;
      oe_reg      <= in_read_reg && !ce_rise;
      rd_data_reg <= rd_data_next;
    end
  end

  assign data_o    = rd_data_reg;
  assign data_oe_o = oe_reg;

  // ****************************************
  // DAC word snapshot, request/acknowledge toggles
  // ****************************************
  logic       snap_req_reg, ack_s1_reg, ack_s2_reg, ack_s3_reg;
  logic       snap_ack_reg;
  logic [7:0] snap_word_reg;

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      snap_req_reg <= 1'b0;
      ack_s1_reg   <= 1'b0;
      ack_s2_reg   <= 1'b0;
      ack_s3_reg   <= 1'b0;
      dac_snap_reg <= 8'h00;
    end
    else
    begin
      ack_s1_reg <= snap_ack_reg;
      ack_s2_reg <= ack_s1_reg;
      ack_s3_reg <= ack_s2_reg;
      // Word is held stable by the pixel side until the next request
      if (ack_s2_reg != ack_s3_reg)
        dac_snap_reg <= snap_word_reg;
      if (ack_s2_reg == snap_req_reg && ack_s2_reg == ack_s3_reg)
        snap_req_reg <= ~snap_req_reg;
    end
  end

  // ****************************************
  // Pixel domain reset and input synchronisers
  // ****************************************
  pdhp_pkg::pdhp_pixbus_type bus_s1_reg, bus_s2_reg, lat_reg;
  pdhp_pkg::pdhp_cfg_type    cfg_s1_reg, cfg_s2_reg;
  logic prst_s1_reg, prst_n_reg;
  logic ld_s1_reg, ld_s2_reg, ld_s3_reg, ld_rise;
  logic req_s1_reg, req_s2_reg, req_s3_reg;

  always_ff @(posedge pix_clk_i)
  begin
    prst_s1_reg <= rst_n_i;
    prst_n_reg  <= prst_s1_reg;
  end

  always_ff @(posedge pix_clk_i)
  begin
    if (!prst_n_reg)
    begin
      ld_s1_reg  <= 1'b1;
      ld_s2_reg  <= 1'b1;
      ld_s3_reg  <= 1'b1;
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_s3_reg <= 1'b0;
    end
    else
    begin
      ld_s1_reg  <= load_strobe_n_i;
      ld_s2_reg  <= ld_s1_reg;
      ld_s3_reg  <= ld_s2_reg;
      req_s1_reg <= snap_req_reg;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
    end
  end

  // Pixel bus and config run through the same two stages
  always_ff @(posedge pix_clk_i)
  begin
    bus_s1_reg <= {pixel_index_in_i, overlay_select_in_i, blank_n_i, sync_n_i};
    bus_s2_reg <= bus_s1_reg;
    cfg_s1_reg <= {cmd_reg[pdhp_pkg::CMD_MUX_BIT], cmd_reg[pdhp_pkg::CMD_PEN_BIT],
                   rmask_reg};
    cfg_s2_reg <= cfg_s1_reg;
  end

  assign ld_rise = ld_s2_reg & ~ld_s3_reg;

  // ****************************************
  // Pixel multiplexer and colour select
  // ****************************************
  logic [2:0] slot_reg, slot_last;
  logic [7:0] cur_idx, pal_idx, color;
  logic [1:0] cur_ovl;
  logic       blank_reg, sync_reg;

  assign slot_last = cfg_s2_reg.mux5 ? pdhp_pkg::LAST_5TO1 : pdhp_pkg::LAST_4TO1;

  // Strobe edge restarts the sequence, so any strobe phase works
  always_ff @(posedge pix_clk_i)
  begin
    if (!prst_n_reg)
    begin
      slot_reg <= 3'h0;
      lat_reg  <= '0;
    end
    else if (ld_rise)
    begin
      lat_reg  <= bus_s2_reg;
      slot_reg <= 3'h0;
    end
    else if (slot_reg >= slot_last)
      slot_reg <= 3'h0;
    else
      slot_reg <= slot_reg + 3'h1;
  end

  assign cur_idx = lat_reg.pix[pdhp_pkg::PIX_W*slot_reg +: pdhp_pkg::PIX_W];
  assign cur_ovl = lat_reg.ovl[pdhp_pkg::OVL_W*slot_reg +: pdhp_pkg::OVL_W];
  assign pal_idx = cur_idx & cfg_s2_reg.rmask;

  always_comb
  begin
    if (cur_ovl == 2'b00 && cfg_s2_reg.pal_en)
      color = pal_mem[pal_idx];
    else
      color = ovl_mem[cur_ovl];
  end

  always_ff @(posedge pix_clk_i)
  begin
    if (!prst_n_reg)
    begin
      dac_data_o <= 8'h00;
      blank_reg  <= 1'b1;
      sync_reg   <= 1'b0;
    end
    else
    begin
      dac_data_o <= lat_reg.blank_n ? color : 8'h00;
      blank_reg  <= ~lat_reg.blank_n;
      sync_reg   <= lat_reg.sync_n;
    end
  end

  assign blank_level_o     = blank_reg;
  assign pll_current_on_o  = blank_reg;
  assign sync_current_on_o = sync_reg;

  always_ff @(posedge pix_clk_i)
  begin
    if (!prst_n_reg)
    begin
      snap_ack_reg  <= 1'b0;
      snap_word_reg <= 8'h00;
    end
    else if (req_s2_reg != req_s3_reg)
    begin
      snap_word_reg <= dac_data_o;
      snap_ack_reg  <= ~snap_ack_reg;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_diag_low_only: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ce_rise && !rw_lat_reg && cmd_lat_reg == pdhp_pkg::CMD_CTL && addr_reg == pdhp_pkg::ADR_DIAG
    |=> diag_reg == $past(dat_s2[3:0]))
    else $error("diag write not low nibble");

  a_diag_read_back: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmd_lat_reg == pdhp_pkg::CMD_CTL && addr_reg == pdhp_pkg::ADR_DIAG && $stable(diag_reg)
    |=> rd_data_reg[3:0] == $past(diag_reg))
    else $error("diag read low bits wrong");

  a_oe_read_only: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    data_oe_o |-> rw_lat_reg && !ce_s3_reg)
    else $error("bus driven outside read");

  a_ce_high_idle: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ce_s2 && ce_s3_reg |=> $stable(addr_reg) && !data_oe_o)
    else $error("activity with chip enable high");

  a_addr_advance: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ce_rise && color_acc && !triplet |=> addr_reg == $past(addr_reg) + 8'h01)
    else $error("address did not advance");

  a_triplet_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ce_rise && color_acc && triplet && phase_reg != pdhp_pkg::RGB_BLUE
    |=> $stable(addr_reg))
    else $error("address moved mid triplet");

  a_load_restart: assert property (@(posedge pix_clk_i) disable iff (!prst_n_reg)
    ld_rise |=> slot_reg == 3'h0 && lat_reg == $past(bus_s2_reg))
    else $error("load did not restart sequence");

  a_slot_step: assert property (@(posedge pix_clk_i) disable iff (!prst_n_reg)
    !ld_rise && slot_reg < slot_last |=> slot_reg == $past(slot_reg) + 3'h1)
    else $error("pixel slot did not step");

  a_slot_bound: assert property (@(posedge pix_clk_i) disable iff (!prst_n_reg)
    ##1 slot_reg <= pdhp_pkg::LAST_5TO1 && (cfg_s2_reg.mux5 || $past(cfg_s2_reg.mux5)
    || slot_reg <= pdhp_pkg::LAST_4TO1))
    else $error("fifth pixel used in 4:1");

  a_blank_zero: assert property (@(posedge pix_clk_i) disable iff (!prst_n_reg)
    !lat_reg.blank_n |=> dac_data_o == 8'h00 && blank_level_o)
    else $error("blank did not force zero");

  a_pll_blank: assert property (@(posedge pix_clk_i) disable iff (!prst_n_reg)
    ##1 pll_current_on_o == !$past(lat_reg.blank_n))
    else $error("lock reference wrong");

  c_triplet_write: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    ce_rise && triplet && !rw_lat_reg && phase_reg == pdhp_pkg::RGB_BLUE);
  c_diag_read: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    data_oe_o && cmd_lat_reg == pdhp_pkg::CMD_CTL && addr_reg == pdhp_pkg::ADR_DIAG);
  c_five_pixels: cover property (@(posedge pix_clk_i) disable iff (!prst_n_reg)
    slot_reg == pdhp_pkg::LAST_5TO1 ##1 slot_reg == 3'h0);

endmodule : pdhp_port

// ---- pdhp_fb.sv ----
// Frame buffer side model that feeds the pixel link
`timescale 1ns/1ns
module pdhp_fb (
  input  wire logic                      pix_clk_i,  // Pixel clock
  input  wire logic                      rst_n_i,    // Reset, active low
  input  wire logic                      five_i,     // 1 strobe at a fifth, 0 a quarter
  input  wire pdhp_pkg::pdhp_pixbus_type next_i,     // Word for the next loads
  output logic                           load_n_o,   // Load strobe, rises to capture
  output pdhp_pkg::pdhp_pixbus_type      bus_o       // Word on the link
);
  logic [2:0] phase_reg;
  logic [2:0] last;

  // ****************************************
  // Strobe at a quarter or a fifth of the pixel rate
  // ****************************************
  assign last = five_i ? pdhp_pkg::LAST_5TO1 : pdhp_pkg::LAST_4TO1;

  always_ff @(posedge pix_clk_i)
  begin
    if (!rst_n_i || phase_reg >= last)
      phase_reg <= 3'h0;
    else
      phase_reg <= phase_reg + 3'h1;
  end

  assign load_n_o = phase_reg >= 3'h2;

  // Word changes two clocks or more away from the capturing rise
  always_ff @(posedge pix_clk_i)
  begin
    if (!rst_n_i || phase_reg == last)
      bus_o <= next_i;
  end
endmodule : pdhp_fb

// ---- tb_palette_dac_host_pixel_port.sv ----
// Self-checking testbench for the palette DAC host and pixel port
`timescale 1ns/1ns
module tb_palette_dac_host_pixel_port;
  logic                      mclk_i, pix_clk_i, rst_n_i, ce_n_i, rw_i;
  logic                      cmd_sel_0_i, cmd_sel_1_i, data_oe_o, load_n, oe, five;
  logic                      blank_level_o, sync_current_on_o, pll_current_on_o;
  logic [7:0]                data_i, data_o, dac_data_o, bus_drv, rd;
  pdhp_pkg::pdhp_pixbus_type next_word, link;
  int                        fail_count, samples_checked;

  // Shared data bus: the design drives it only while enabled
  assign data_i = data_oe_o ? data_o : bus_drv;

  initial
  begin
    mclk_i = 1'h0;
    forever #50 mclk_i = ~mclk_i;
  end

  initial
  begin
    pix_clk_i = 1'h0;
    #13;
    forever #40 pix_clk_i = ~pix_clk_i;
  end

  pdhp_port dut (
    .mclk_i, .rst_n_i, .pix_clk_i, .ce_n_i, .rw_i, .cmd_sel_0_i, .cmd_sel_1_i,
    .data_i, .data_o, .data_oe_o, .load_strobe_n_i (load_n),
    .pixel_index_in_i (link.pix), .overlay_select_in_i (link.ovl),
    .blank_n_i (link.blank_n), .sync_n_i (link.sync_n), .dac_data_o,
    .blank_level_o, .sync_current_on_o, .pll_current_on_o);

  pdhp_fb far (.pix_clk_i, .rst_n_i, .five_i (five), .next_i (next_word),
    .load_n_o (load_n), .bus_o (link));

  // ****************************************
  // Tasks
  // ****************************************
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : chk

  // One host cycle; CE held low 8 clocks, high 6
  task acc(input logic r, input logic [1:0] c, input logic [7:0] w);
    @(negedge mclk_i);
    ce_n_i = 1'h0;
    rw_i = r;
    {cmd_sel_1_i, cmd_sel_0_i} = c;
    bus_drv = w;
    repeat (8) @(negedge mclk_i);
    rd = data_o;
    oe = data_oe_o;
    ce_n_i = 1'h1;
    repeat (6) @(negedge mclk_i);
    bus_drv = ~w;
  endtask : acc

  task set_reg(input logic [7:0] adr, input logic [7:0] v);
    acc(1'h0, pdhp_pkg::CMD_ADDR, adr);
    acc(1'h0, pdhp_pkg::CMD_CTL, v);
  endtask : set_reg

  task rd_reg(input logic [7:0] adr);
    acc(1'h0, pdhp_pkg::CMD_ADDR, adr);
    acc(1'h1, pdhp_pkg::CMD_CTL, 8'h00);
  endtask : rd_reg

  // New link word, then time for capture and config crossing
  task pix(input logic [9:0] o, input logic b, input logic s);
    next_word = {8'h00, {4{8'h33}}, o, b, s};
    repeat (30) @(negedge mclk_i);
  endtask : pix

  task dac_chk(input logic [7:0] exp);
    repeat (8)
    begin
      @(negedge pix_clk_i);
      chk("dac word", exp, dac_data_o);
    end
  endtask : dac_chk

  // Pixel A shows four pixel clocks after the strobe rise, then B onward
  task seq_chk(input logic [39:0] exp, input int n);
    int k;
    k = 0;
    while (k < 8 && load_n)
    begin
      @(posedge pix_clk_i);
      k++;
    end
    while (k < 16 && !load_n)
    begin
      @(posedge pix_clk_i);
      k++;
    end
    if (k >= 16)
    begin
      fail_count++;
      end_of_test;
    end
    repeat (3) @(posedge pix_clk_i);
    for (k = 0; k < n; k++)
    begin
      @(negedge pix_clk_i);
      chk("dac order", exp[8*k +: 8], dac_data_o);
    end
  endtask : seq_chk

  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  initial
  begin
    #2000000;
    fail_count++;
    end_of_test;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    fail_count = 0;
    samples_checked = 0;
    rst_n_i = 1'h0;
    ce_n_i = 1'h1;
    rw_i = 1'h1;
    {cmd_sel_1_i, cmd_sel_0_i} = 2'h0;
    bus_drv = 8'h00;
    five = 1'h0;
    next_word = {8'h00, {4{8'h33}}, 10'h000, 1'h1, 1'h1};
    repeat (10) @(negedge mclk_i);
    rst_n_i = 1'h1;
    repeat (3) @(negedge mclk_i);
    set_reg(pdhp_pkg::ADR_DIAG, 8'hF8);
    acc(1'h0, pdhp_pkg::CMD_ADDR, 8'h00);
    acc(1'h0, pdhp_pkg::CMD_OVL, 8'h5A);
    chk("drive on write", 8'h00, {7'h00, oe});
    acc(1'h0, pdhp_pkg::CMD_OVL, 8'h96);
    pix(10'h000, 1'h1, 1'h1);
    dac_chk(8'h5A);
    rd_reg(pdhp_pkg::ADR_DIAG);
    chk("diag low nibble", 8'hA8, rd);
    set_reg(pdhp_pkg::ADR_DIAG, 8'h00);
    rd_reg(pdhp_pkg::ADR_DIAG);
    chk("diag high nibble", 8'h50, rd);
    rd_reg(8'h01);
    chk("unmapped", 8'h00, rd);
    set_reg(pdhp_pkg::ADR_CMD, 8'h40);
    acc(1'h0, pdhp_pkg::CMD_ADDR, 8'h33);
    acc(1'h0, pdhp_pkg::CMD_PAL, 8'hC3);
    acc(1'h0, pdhp_pkg::CMD_PAL, 8'h77);
    acc(1'h0, pdhp_pkg::CMD_ADDR, 8'h03);
    acc(1'h0, pdhp_pkg::CMD_PAL, 8'h3C);
    acc(1'h0, pdhp_pkg::CMD_ADDR, 8'h33);
    acc(1'h1, pdhp_pkg::CMD_PAL, 8'h00);
    chk("palette 33", 8'hC3, rd);
    chk("drive on read", 8'h01, {7'h00, oe});
    acc(1'h1, pdhp_pkg::CMD_PAL, 8'h00);
    chk("palette 34", 8'h77, rd);
    pix(10'h000, 1'h1, 1'h1);
    dac_chk(8'hC3);
    pix(10'h155, 1'h1, 1'h1);
    dac_chk(8'h96);
    set_reg(pdhp_pkg::ADR_RMASK, 8'h0F);
    pix(10'h000, 1'h1, 1'h1);
    dac_chk(8'h3C);
    acc(1'h0, pdhp_pkg::CMD_ADDR, 8'h02);
    acc(1'h0, pdhp_pkg::CMD_OVL, 8'hE1);
    pix(10'h064, 1'h1, 1'h1);
    seq_chk(40'h0096E1963C, 4);
    set_reg(pdhp_pkg::ADR_CMD, 8'hC0);
    five = 1'h1;
    pix(10'h264, 1'h1, 1'h1);
    seq_chk(40'hE196E1963C, 5);
    pix(10'h000, 1'h0, 1'h1);
    dac_chk(8'h00);
    chk("blank level", 8'h01, {7'h00, blank_level_o});
    chk("lock current", 8'h01, {7'h00, pll_current_on_o});
    pix(10'h000, 1'h0, 1'h0);
    chk("sync current", 8'h00, {7'h00, sync_current_on_o});
    pix(10'h000, 1'h1, 1'h1);
    chk("sync current", 8'h01, {7'h00, sync_current_on_o});
    chk("lock current", 8'h00, {7'h00, pll_current_on_o});
    set_reg(pdhp_pkg::ADR_DIAG, 8'h02);
    acc(1'h0, pdhp_pkg::CMD_ADDR, 8'h10);
    acc(1'h0, pdhp_pkg::CMD_PAL, 8'h11);
    acc(1'h0, pdhp_pkg::CMD_PAL, 8'h22);
    acc(1'h0, pdhp_pkg::CMD_PAL, 8'h33);
    acc(1'h0, pdhp_pkg::CMD_ADDR, 8'h10);
    acc(1'h1, pdhp_pkg::CMD_PAL, 8'h00);
    chk("red cycle drive", 8'h00, {7'h00, oe});
    acc(1'h1, pdhp_pkg::CMD_PAL, 8'h00);
    chk("green cycle data", 8'h22, rd);
    chk("green cycle drive", 8'h01, {7'h00, oe});
    acc(1'h1, pdhp_pkg::CMD_PAL, 8'h00);
    chk("blue cycle drive", 8'h00, {7'h00, oe});
    end_of_test;
  end
endmodule : tb_palette_dac_host_pixel_port
